// ==== pkg/hs_pkg.sv ====
package hs_pkg;

  // Register addresses on the 7-bit register port.
  localparam logic [6:0] TIMER_A_ADDR   = 7'h0c;
  localparam logic [6:0] TIMER_B_ADDR   = 7'h0d;
  localparam logic [6:0] POLICY_ADDR    = 7'h10;
  localparam logic [6:0] SRC_LO_ADDR    = 7'h14;
  localparam logic [6:0] SRC_HI_ADDR    = 7'h15;
  localparam logic [6:0] DUTY_A_ADDR    = 7'h18;
  localparam logic [6:0] DUTY_B_ADDR    = 7'h19;
  localparam logic [6:0] DUTY_FREQ_ADDR = 7'h1c;

  // Reset value and writable-bit masks; reserved bits stay zero.
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] TIMER_MASK  = 8'h77;
  localparam logic [7:0] POLICY_MASK = 8'h70;
  localparam logic [7:0] SRC_MASK    = 8'h77;
  localparam logic [7:0] DUTY_MASK   = 8'hff;
  localparam logic [7:0] FREQ_MASK   = 8'h05;
  localparam int         FREQ_A_BIT  = 0;
  localparam int         FREQ_B_BIT  = 2;

  // Field layouts of the byte-wide registers.
  typedef struct packed {
    logic       rsv_hi;
    logic [2:0] on_code;
    logic       rsv_lo;
    logic [2:0] per_code;
  } timer_ctrl_t;

  typedef struct packed {
    logic       rsv_hi;
    logic [2:0] src_hi;
    logic       rsv_lo;
    logic [2:0] src_lo;
  } src_pair_t;

  typedef struct packed {
    logic       rsv_hi;
    logic       ov_dis;
    logic       uv_dis;
    logic       recover;
    logic [3:0] rsv_lo;
  } policy_t;

  // Timer and source codes.
  localparam logic [2:0] ON_LOW  = 3'h0;
  localparam logic [2:0] ON_HIGH = 3'h6;
  localparam logic [2:0] CODE_RSV = 3'h7;
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON  = 3'h1;
  localparam logic [2:0] SRC_TA  = 3'h2;
  localparam logic [2:0] SRC_TB  = 3'h3;
  localparam logic [2:0] SRC_DA  = 3'h4;
  localparam logic [2:0] SRC_DB  = 3'h5;

  // Clock rate and the microsecond timebase of the cycle timers.
  localparam int CLK_HZ  = 250_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int CNT_W   = 21;

  // Duty channel timebase: 255 steps per cycle at 200 Hz or 400 Hz.
  localparam int         DUTY_LO_HZ = 200;
  localparam int         DUTY_HI_HZ = 400;
  localparam int         DUTY_STEPS = 255;
  localparam logic [7:0] DUTY_LAST  = 8'(DUTY_STEPS - 1);
  localparam int DUTY_LO_STEP_CYC = CLK_HZ / (DUTY_LO_HZ * DUTY_STEPS);
  localparam int DUTY_HI_STEP_CYC = CLK_HZ / (DUTY_HI_HZ * DUTY_STEPS);

  // On-time in microseconds; zero for the non-running codes.
  function automatic logic [CNT_W-1:0] on_time_us(input logic [2:0] code);
    case (code)
      3'h1:    on_time_us = 21'd100;
      3'h2:    on_time_us = 21'd300;
      3'h3:    on_time_us = 21'd1000;
      3'h4:    on_time_us = 21'd10000;
      3'h5:    on_time_us = 21'd20000;
      default: on_time_us = 21'd0;
    endcase
  endfunction : on_time_us

  // Period in microseconds; the reserved code reads as zero.
  function automatic logic [CNT_W-1:0] period_us(input logic [2:0] code);
    case (code)
      3'h0:    period_us = 21'd10000;
      3'h1:    period_us = 21'd20000;
      3'h2:    period_us = 21'd50000;
      3'h3:    period_us = 21'd100000;
      3'h4:    period_us = 21'd200000;
      3'h5:    period_us = 21'd1000000;
      3'h6:    period_us = 21'd2000000;
      default: period_us = 21'd0;
    endcase
  endfunction : period_us

endpackage : hs_pkg

// ==== rtl/hs_switch_ctrl.sv ====
// What this block does
// R01: Decode on-time codes one to five.
// R02: On codes zero and six stop timer, hold level.
// R03: Decode period codes zero to six.
// R04: Timer starts when a running on-time is written.
// R05: Restart with cyclic sense also clears timer fields.
// R06: Reserved bits read zero, writes ignored.
// R07: Second timer clears on resets and restart entry.
// R08: Policy clears on resets, keeps bits on restart.
// R09: Overvoltage switches all off unless disabled.
// R10: Undervoltage switches all off unless disabled.
// R11: Recovery bit restores switches after supply fault.
// R12: Decode switch source codes.
// R13: Switches one and two in low register.
// R14: Switches three and four in high register.
// R15: Overcurrent or overtemperature clears that switch source.
// R16: First timer register at its own address.
// R17: Duty output fully on for value 255.
// R18: Duty channel runs at 200 or 400 Hz.
// R19: Hardware-updated fields read current value.
//
// The implementer's own choice: strobed register access.
module hs_switch_ctrl
  import hs_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYC,
  parameter int DUTY_LO_STEP = DUTY_LO_STEP_CYC,
  parameter int DUTY_HI_STEP = DUTY_HI_STEP_CYC
)(
  // Clock and reset.
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // Device state events.
  input  wire logic       SOFT_RST,
  input  wire logic       RESTART_ENTRY,
  input  wire logic       CYCLIC_SENSE,
  // Register port.
  input  wire logic [6:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Fault pins, asynchronous to MCLK.
  input  wire logic       SUPPLY_OV,
  input  wire logic       SUPPLY_UV,
  input  wire logic [3:0] OVERCURRENT,
  input  wire logic [3:0] OVERTEMP,
  // High-side switch drive.
  output logic      [3:0] SWITCH_ON
);

  // The tick and duty step counters are 16 bits wide; anything else cannot be served.
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || DUTY_HI_STEP < 1 ||
      DUTY_LO_STEP < DUTY_HI_STEP || DUTY_LO_STEP > 65535)
  begin : g_bad_param
    $error("hs_switch_ctrl: timing parameter out of range.");
  end

  localparam int NPIN = 10;

  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_d;
  wire  [NPIN-1:0] pin_raw;
  logic            ov_l;
  logic            uv_l;
  logic [3:0]      oc_l;
  logic [3:0]      ot_l;

  // A pin level is taken only once the second and third stages agree.
  assign pin_raw = {OVERTEMP, OVERCURRENT, SUPPLY_UV, SUPPLY_OV};
  assign pin_d   = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
  assign ov_l    = pin_q[0];
  assign uv_l    = pin_q[1];
  assign oc_l    = pin_q[5:2];
  assign ot_l    = pin_q[9:6];

  // Three-stage input synchroniser with agreement filter.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end
    else
    begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end

  timer_ctrl_t tmr_q [2];
  timer_ctrl_t tmr_d [2];
  src_pair_t   src_q [2];
  src_pair_t   src_d [2];
  policy_t     pol_q;
  policy_t     pol_d;
  logic [7:0]  duty_q [2];
  logic [7:0]  duty_d [2];
  logic [7:0]  freq_q;
  logic [7:0]  freq_d;
  logic        fault_q;
  wire         fault;
  wire         drop_src;
  wire  [3:0]  sw_kill;
  wire  [1:0]  wr_tmr;
  wire  [1:0]  wr_src;
  wire  [1:0]  wr_duty;
  wire         wr_pol;
  wire         wr_freq;
  wire         wipe;

  // Write decode.
  assign wr_tmr[0]  = WR && ADDR == TIMER_A_ADDR; // R16
  assign wr_tmr[1]  = WR && ADDR == TIMER_B_ADDR;
  assign wr_src[0]  = WR && ADDR == SRC_LO_ADDR;
  assign wr_src[1]  = WR && ADDR == SRC_HI_ADDR;
  assign wr_duty[0] = WR && ADDR == DUTY_A_ADDR;
  assign wr_duty[1] = WR && ADDR == DUTY_B_ADDR;
  assign wr_pol     = WR && ADDR == POLICY_ADDR;
  assign wr_freq    = WR && ADDR == DUTY_FREQ_ADDR;
  assign wipe       = SOFT_RST || RESTART_ENTRY;

  // A supply fault whose shutdown is enabled forces every switch off.
  assign fault    = (ov_l & ~pol_q.ov_dis) | (uv_l & ~pol_q.uv_dis); // R09 R10
  // Without recovery the sources are dropped as the fault ends, so the
  // switches stay off until software writes them again.
  assign drop_src = fault_q & ~fault & ~pol_q.recover; // R11
  assign sw_kill  = {4{drop_src}} | oc_l | ot_l; // R15

  // Next values of the switch source registers; hardware clears win over
  // a write in the same cycle, since they protect the load.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      src_d[i] = src_q[i];
      if (wr_src[i])
        src_d[i] = src_pair_t'(WDATA & SRC_MASK); // R06 R13 R14
      if (sw_kill[2*i])
        src_d[i].src_lo = SRC_OFF; // R15
      if (sw_kill[2*i+1])
        src_d[i].src_hi = SRC_OFF; // R15
      if (wipe)
        src_d[i] = src_pair_t'(REG_RESET);
    end
  end

  // Next values of timers, policy and duty registers.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      tmr_d[i]  = wr_tmr[i] ? timer_ctrl_t'(WDATA & TIMER_MASK) : tmr_q[i]; // R06
      duty_d[i] = wr_duty[i] ? (WDATA & DUTY_MASK) : duty_q[i];
      if (wipe)
        tmr_d[i] = timer_ctrl_t'(REG_RESET); // R05 R07
      if (SOFT_RST)
        duty_d[i] = REG_RESET;
    end
    pol_d  = wr_pol ? policy_t'(WDATA & POLICY_MASK) : pol_q; // R06
    freq_d = wr_freq ? (WDATA & FREQ_MASK) : freq_q;
    if (SOFT_RST)
    begin
      pol_d  = policy_t'(REG_RESET); // R08
      freq_d = REG_RESET;
    end
  end

  // Register storage; restart keeps the policy bits untouched.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      tmr_q   <= '{2{timer_ctrl_t'(REG_RESET)}}; // R07
      src_q   <= '{2{src_pair_t'(REG_RESET)}};
      duty_q  <= '{2{REG_RESET}};
      pol_q   <= policy_t'(REG_RESET); // R08
      freq_q  <= REG_RESET;
      fault_q <= 1'b0;
    end
    else
    begin
      tmr_q   <= tmr_d;
      src_q   <= src_d;
      duty_q  <= duty_d;
      pol_q   <= pol_d;
      freq_q  <= freq_d;
      fault_q <= fault;
    end
  end

  logic [15:0] tick_q;
  wire         tick;

  // Shared microsecond tick for both cycle timers.
  assign tick = tick_q == 16'(TICK_CYCLES - 1);

  always_ff @(posedge MCLK)
  begin
    if (!RST_N || tick)
      tick_q <= 16'h0000;
    else
      tick_q <= tick_q + 16'h0001;
  end

  logic [CNT_W-1:0] tcnt_q [2];
  logic [1:0]       tmr_run;
  logic [1:0]       tmr_out;
  logic [15:0]      dstep_q [2];
  logic [7:0]       phase_q [2];
  logic [1:0]       duty_out;
  wire  [1:0]       freq_sel;

  assign freq_sel = {freq_q[FREQ_B_BIT], freq_q[FREQ_A_BIT]};

  for (genvar t = 0; t < 2; t++)
  begin : g_chan
    wire [CNT_W-1:0] per_us;
    wire [CNT_W-1:0] on_us;
    wire [15:0]      step_last;
    wire             step;

    assign per_us = period_us(tmr_q[t].per_code); // R03
    assign on_us  = on_time_us(tmr_q[t].on_code); // R01
    // Stopped codes and the reserved codes leave the timer idle.
    assign tmr_run[t] = tmr_q[t].on_code != ON_LOW && tmr_q[t].on_code != ON_HIGH &&
                        tmr_q[t].on_code != CODE_RSV && tmr_q[t].per_code != CODE_RSV; // R02
    assign tmr_out[t] = tmr_run[t] ? (tcnt_q[t] < on_us)
                                   : (tmr_q[t].on_code == ON_HIGH); // R02

    // A write restarts the cycle, so a new on-time starts cleanly.
    always_ff @(posedge MCLK)
    begin
      if (!RST_N || !tmr_run[t] || wr_tmr[t])
        tcnt_q[t] <= '0; // R04
      else if (tick)
        tcnt_q[t] <= (tcnt_q[t] >= per_us - 21'd1) ? '0 : tcnt_q[t] + 21'd1;
    end

    // Step length picks 200 Hz or 400 Hz for the 255-step cycle.
    assign step_last = freq_sel[t] ? 16'(DUTY_HI_STEP - 1) : 16'(DUTY_LO_STEP - 1); // R18
    assign step      = dstep_q[t] >= step_last;
    // Phase runs 0..254, so 255 never compares below and stays on.
    assign duty_out[t] = phase_q[t] < duty_q[t]; // R17

    always_ff @(posedge MCLK)
    begin
      if (!RST_N)
      begin
        dstep_q[t] <= 16'h0000;
        phase_q[t] <= 8'h00;
      end
      else
      begin
        dstep_q[t] <= step ? 16'h0000 : dstep_q[t] + 16'h0001;
        if (step)
          phase_q[t] <= (phase_q[t] == DUTY_LAST) ? 8'h00 : phase_q[t] + 8'h01; // R18
      end
    end
  end

  // Source selection for one switch.
  function automatic logic src_level(input logic [2:0] code, input logic [1:0] tm,
                                     input logic [1:0] dc);
    case (code)
      SRC_ON:  src_level = 1'b1;
      SRC_TA:  src_level = tm[0];
      SRC_TB:  src_level = tm[1];
      SRC_DA:  src_level = dc[0];
      SRC_DB:  src_level = dc[1];
      default: src_level = 1'b0;
    endcase // R12
  endfunction : src_level

  wire [3:0] sw_d;

  assign sw_d[0] = src_level(src_q[0].src_lo, tmr_out, duty_out) & ~fault; // R09 R10
  assign sw_d[1] = src_level(src_q[0].src_hi, tmr_out, duty_out) & ~fault;
  assign sw_d[2] = src_level(src_q[1].src_lo, tmr_out, duty_out) & ~fault;
  assign sw_d[3] = src_level(src_q[1].src_hi, tmr_out, duty_out) & ~fault;

  // Switch drive is registered so the pins never glitch on decode.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      SWITCH_ON <= 4'h0;
    else
      SWITCH_ON <= sw_d;
  end

  wire [7:0] rd_mux;

  // Read decode shows live register state, hardware clears included.
  assign rd_mux = (ADDR == TIMER_A_ADDR)   ? 8'(tmr_q[0]) : // R19
                  (ADDR == TIMER_B_ADDR)   ? 8'(tmr_q[1]) :
                  (ADDR == POLICY_ADDR)    ? 8'(pol_q) :
                  (ADDR == SRC_LO_ADDR)    ? 8'(src_q[0]) :
                  (ADDR == SRC_HI_ADDR)    ? 8'(src_q[1]) :
                  (ADDR == DUTY_A_ADDR)    ? duty_q[0] :
                  (ADDR == DUTY_B_ADDR)    ? duty_q[1] :
                  (ADDR == DUTY_FREQ_ADDR) ? freq_q : 8'h00; // R06

  // Read data stand for exactly one cycle after the read strobe.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N || !RD)
      RDATA <= 8'h00;
    else
      RDATA <= rd_mux;
  end

endmodule : hs_switch_ctrl

// ==== verification/hs_load_model.sv ====
// Switch loads: a shorted or hot load only reports a fault while its switch conducts.
module hs_load_model (
  // Clock and drive from the switch block.
  input  wire logic       clk,
  input  wire logic [3:0] drive,
  // Fault requests and counter clear from the bench.
  input  wire logic [3:0] shorted,
  input  wire logic [3:0] hot,
  input  wire logic       clear,
  // Fault pins back to the switch block.
  output logic      [3:0] over_current,
  output logic      [3:0] over_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  int   on_cnt = 0;
  int   rise_cnt = 0;
  logic prev_q = 1'b0;

  // Faults follow the drive; switch one is measured for on-time and edges.
  always @(posedge clk)
  begin
    over_current <= drive & shorted;
    over_temp    <= drive & hot;
    prev_q       <= drive[0];
    on_cnt       <= clear ? 0 : on_cnt + int'(drive[0]);
    rise_cnt     <= clear ? 0 : rise_cnt + int'(drive[0] && !prev_q);
  end
endmodule : hs_load_model

// ==== verification/hs_switch_ctrl_sva.sv ====
module hs_switch_ctrl_sva
  import hs_pkg::*;
(
  // Clock, reset and events.
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic       SOFT_RST,
  input wire logic       RESTART_ENTRY,
  input wire logic       CYCLIC_SENSE,
  // Register port.
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Faults and drive.
  input wire logic       SUPPLY_OV,
  input wire logic       SUPPLY_UV,
  input wire logic [3:0] OVERCURRENT,
  input wire logic [3:0] OVERTEMP,
  input wire logic [3:0] SWITCH_ON
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tb_q;
  logic [7:0] pol_q;
  wire        mapped = ADDR inside {TIMER_A_ADDR, TIMER_B_ADDR, POLICY_ADDR, SRC_LO_ADDR, SRC_HI_ADDR,
                                    DUTY_A_ADDR, DUTY_B_ADDR, DUTY_FREQ_ADDR};

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // Shadows of the two registers that only software, resets and restart entry change.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N || SOFT_RST)
    begin
      tb_q  <= 8'h00;
      pol_q <= 8'h00;
    end
    else
    begin
      if (RESTART_ENTRY)
        tb_q <= 8'h00;
      else if (WR && ADDR == TIMER_B_ADDR)
        tb_q <= WDATA & TIMER_MASK;
      if (WR && ADDR == POLICY_ADDR)
        pol_q <= WDATA & POLICY_MASK;
    end
  end

  a_unmapped_read_zero: assert property ($past(RD) && !$past(mapped) |-> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_timer_readback: assert property ($past(RD) && $past(ADDR) == TIMER_B_ADDR |-> RDATA == $past(tb_q))
    else $error("timer register read back wrong");
  a_policy_readback: assert property ($past(RD) && $past(ADDR) == POLICY_ADDR |-> RDATA == $past(pol_q))
    else $error("policy register read back wrong");
  a_ov_shutdown: assert property ((SUPPLY_OV && !pol_q[6]) [*8] |-> SWITCH_ON == 4'h0)
    else $error("switches on during overvoltage");
  a_uv_shutdown: assert property ((SUPPLY_UV && !pol_q[5]) [*8] |-> SWITCH_ON == 4'h0)
    else $error("switches on during undervoltage");
  a_current_clears: assert property ($rose(OVERCURRENT[0]) |-> ##[1:8] !SWITCH_ON[0])
    else $error("switch one kept on after overcurrent");
  a_heat_clears: assert property ($rose(OVERTEMP[1]) |-> ##[1:8] !SWITCH_ON[1])
    else $error("switch two kept on after overtemperature");
  a_restart_off: assert property (RESTART_ENTRY |-> ##2 SWITCH_ON == 4'h0)
    else $error("switches on after restart entry");
  a_soft_off: assert property (SOFT_RST |-> ##2 SWITCH_ON == 4'h0)
    else $error("switches on after soft reset");

  c_fault_end: cover property ($fell(SUPPLY_OV));
  c_restart: cover property (RESTART_ENTRY);
  c_short: cover property ($rose(OVERCURRENT[0]));
  c_unmapped: cover property (RD && !mapped);
endmodule : hs_switch_ctrl_sva

bind hs_switch_ctrl hs_switch_ctrl_sva chk (.MCLK, .RST_N, .SOFT_RST, .RESTART_ENTRY, .CYCLIC_SENSE, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .SUPPLY_OV, .SUPPLY_UV, .OVERCURRENT, .OVERTEMP, .SWITCH_ON);

// ==== verification/high_side_switch_timer_control_bench.sv ====
module high_side_switch_timer_control_bench
  import hs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  typedef struct {logic [7:0] pol; logic ov; logic [3:0] during; logic [3:0] after;} fault_t;
  logic       mclk = 0, rst_n = 0, soft_rst = 0, restart_entry = 0, cyclic_sense = 0, wr = 0, rd = 0;
  logic       supply_ov = 0, supply_uv = 0, clear = 0;
  logic [6:0] addr = '0;
  logic [7:0] wdata = '0, rdata;
  logic [3:0] shorted = '0, hot = '0, oc, ot, switch_on;
  int         miscompares = 0, samples_checked = 0;
  row_t rows[8] = '{'{TIMER_B_ADDR, 8'hff, 8'h77}, '{TIMER_B_ADDR, 8'h5e, 8'h56}, '{POLICY_ADDR, 8'hff, 8'h70},
    '{SRC_LO_ADDR, 8'hff, 8'h77}, '{SRC_HI_ADDR, 8'h8d, 8'h05}, '{TIMER_A_ADDR, 8'h88, 8'h00},
    '{7'h11, 8'hff, 8'h00}, '{DUTY_FREQ_ADDR, 8'hff, FREQ_MASK}};
  fault_t faults[4] = '{'{8'h00, 1'b1, 4'h0, 4'h0}, '{8'h10, 1'b0, 4'h0, 4'h3}, '{8'h50, 1'b1, 4'h3, 4'h3},
    '{8'h30, 1'b0, 4'h3, 4'h3}};

  hs_switch_ctrl #(.TICK_CYCLES(2), .DUTY_LO_STEP(4), .DUTY_HI_STEP(2)) dut (.MCLK(mclk), .RST_N(rst_n),
    .SOFT_RST(soft_rst), .RESTART_ENTRY(restart_entry), .CYCLIC_SENSE(cyclic_sense), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SUPPLY_OV(supply_ov), .SUPPLY_UV(supply_uv), .OVERCURRENT(oc),
    .OVERTEMP(ot), .SWITCH_ON(switch_on));
  hs_load_model load (.clk(mclk), .drive(switch_on), .shorted(shorted), .hot(hot), .clear(clear),
    .over_current(oc), .over_temp(ot));

  // Clock at 250 MHz.
  initial
  begin
    forever #2 mclk = ~mclk;
  end

  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_near(input int got, input int exp, input int tol);
    samples_checked++;
    if (got < exp - tol || got > exp + tol)
    begin
      miscompares++;
      $display("unexpected at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : check_near

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    @(posedge mclk);
    {rd, addr} <= {1'b1, a};
    @(posedge mclk);
    rd <= 1'b0;
    #1 check_val(rdata, e);
  endtask : rd_chk

  // Counts come from the load model over a window that starts with the write.
  task automatic measure(input logic [6:0] a, input logic [7:0] d, input int win, input int on, input int rise);
    clear <= 1'b1;
    reg_wr(a, d);
    clear <= 1'b0;
    repeat (win) @(posedge mclk);
    #1 check_near(load.on_cnt, on, 8);
    check_near(load.rise_cnt, rise, 1);
  endtask : measure

  // A hang counts as a miscompare.
  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  // Main sequence; the source decode expects bit c set where code c drives high.
  initial
  begin
    logic [7:0] src_exp;
    src_exp = 8'b0001_1010;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) rd_chk(rows[i].a, REG_RESET);
    foreach (rows[i])
    begin
      reg_wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    reg_wr(TIMER_B_ADDR, {1'b0, ON_HIGH, 4'h0});
    reg_wr(TIMER_A_ADDR, 8'h00);
    reg_wr(DUTY_A_ADDR, 8'hff);
    reg_wr(DUTY_B_ADDR, 8'h00);
    reg_wr(SRC_HI_ADDR, {5'h00, SRC_ON});
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(SRC_LO_ADDR, {1'b0, SRC_TB, 1'b0, 3'(c)});
      repeat (3) @(posedge mclk);
      #1 check_val({4'h0, switch_on}, {5'h03, src_exp[c]});
    end
    reg_wr(TIMER_B_ADDR, 8'h00);
    reg_wr(SRC_LO_ADDR, {5'h00, SRC_TB});
    measure(TIMER_B_ADDR, 8'h10, 20300, 400, 2);
    measure(TIMER_B_ADDR, 8'h20, 2000, 600, 1);
    reg_wr(SRC_LO_ADDR, {5'h00, SRC_TA});
    measure(TIMER_A_ADDR, 8'h20, 2000, 600, 1);
    reg_wr(SRC_LO_ADDR, {5'h00, SRC_DA});
    reg_wr(DUTY_A_ADDR, 8'h80);
    measure(DUTY_FREQ_ADDR, 8'h00, 5100, 2560, 5);
    measure(DUTY_FREQ_ADDR, 8'h01, 5100, 2560, 10);
    reg_wr(SRC_LO_ADDR, {5'h00, SRC_DB});
    reg_wr(DUTY_B_ADDR, 8'h80);
    measure(DUTY_FREQ_ADDR, 8'h04, 5100, 2560, 10);
    foreach (faults[i])
    begin
      reg_wr(POLICY_ADDR, faults[i].pol);
      reg_wr(SRC_LO_ADDR, 8'h11);
      {supply_ov, supply_uv} <= {faults[i].ov, !faults[i].ov};
      repeat (12) @(posedge mclk);
      #1 check_val({4'h0, switch_on}, {4'h0, faults[i].during});
      @(posedge mclk);
      {supply_ov, supply_uv} <= 2'b00;
      repeat (12) @(posedge mclk);
      #1 check_val({4'h0, switch_on}, {4'h0, faults[i].after});
    end
    reg_wr(SRC_LO_ADDR, 8'h11);
    shorted <= 4'h1;
    repeat (12) @(posedge mclk);
    rd_chk(SRC_LO_ADDR, 8'h10);
    @(posedge mclk);
    hot <= 4'h2;
    repeat (12) @(posedge mclk);
    rd_chk(SRC_LO_ADDR, 8'h00);
    @(posedge mclk);
    {shorted, hot} <= 8'h00;
    reg_wr(POLICY_ADDR, 8'h70);
    reg_wr(TIMER_B_ADDR, 8'h12);
    reg_wr(SRC_HI_ADDR, 8'h11);
    cyclic_sense <= 1'b1;
    @(posedge mclk);
    restart_entry <= 1'b1;
    @(posedge mclk);
    restart_entry <= 1'b0;
    rd_chk(TIMER_B_ADDR, 8'h00);
    rd_chk(SRC_HI_ADDR, 8'h00);
    rd_chk(POLICY_ADDR, 8'h70);
    reg_wr(SRC_LO_ADDR, 8'h01);
    reg_wr(TIMER_B_ADDR, 8'h12);
    @(posedge mclk);
    soft_rst <= 1'b1;
    @(posedge mclk);
    soft_rst <= 1'b0;
    rd_chk(POLICY_ADDR, 8'h00);
    rd_chk(SRC_LO_ADDR, 8'h00);
    rd_chk(TIMER_B_ADDR, 8'h00);
    stop_test();
  end
endmodule : high_side_switch_timer_control_bench
